// [host_ctrl.sv]
// host controller model driving enable and reading the flag pins
`timescale 1ns/1ps
module host_ctrl (
  // clock
  input wire logic ref_clk,
  // requests from the bench
  input wire logic want_en,
  input wire logic want_sel,
  // pins toward the switch
  output logic enable,
  output logic lockout_sel,
  input wire logic fault_o,
  input wire logic fault_oe,
  input wire logic good_o,
  input wire logic good_oe,
  // flag levels with pull-ups
  output logic fault_pin,
  output logic good_pin
);
  // ------------------------------------------------------------
  // enable is always actively driven, low included
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    enable <= want_en;
    lockout_sel <= want_sel;
  end
  assign fault_pin = fault_oe ? fault_o : 1'b1;
  assign good_pin = good_oe ? good_o : 1'b1;
endmodule // host_ctrl

// [load_switch_pkg.sv]
// shared constants and types for the load switch protection block
package load_switch_pkg;

  // ------------------------------------------------------------
  // clock and protection timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned BLANK_TIME_MS = 18;
  localparam int unsigned RETRY_TIME_MS = 160;
  localparam int unsigned BLANK_CYCLES = CLK_PER_MS * BLANK_TIME_MS;
  localparam int unsigned RETRY_CYCLES = CLK_PER_MS * RETRY_TIME_MS;
  localparam int TIMER_W = 24;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_UPPER_PWR = 8'h04;
  localparam logic [7:0] OFF_LOWER_PWR = 8'h08;
  localparam logic [7:0] OFF_OVERVOLTAGE_CUTOFF_LO = 8'h0c;
  localparam logic [7:0] OFF_OVERVOLTAGE_CUTOFF_HI = 8'h10;
  localparam logic [7:0] OFF_GOOD_THR = 8'h14;
  localparam logic [7:0] OFF_EVENTS = 8'h18;
  localparam logic [7:0] OFF_TRIPS = 8'h1c;
  localparam logic [7:0] OFF_POWER = 8'h20;

  // ------------------------------------------------------------
  // reset values (power lsb 10 mW, voltage lsb 100 mV)
  // ------------------------------------------------------------
  localparam logic [15:0] UPPER_PWR_RST = 16'h09c4;
  localparam logic [15:0] LOWER_PWR_RST = 16'h04e2;
  localparam logic [7:0] OVERVOLTAGE_CUTOFF_LO_RST = 8'hdc;
  localparam logic [7:0] OVERVOLTAGE_CUTOFF_HI_RST = 8'hf0;
  localparam logic [7:0] GOOD_THR_RST = 8'h64;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int STAT_OV = 0;
  localparam int STAT_SEL = 1;
  localparam int STAT_EN = 2;
  localparam int STAT_GOOD = 3;
  localparam int STAT_FAULT = 4;
  localparam int STAT_GATE = 5;
  localparam int STAT_STATE = 6;
  localparam int EV_UPPER = 0;
  localparam int EV_LOWER = 1;
  localparam int EV_OV = 2;
  localparam int EV_W = 3;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {st_off, st_on, st_blank, st_retry} sw_state_t;

  typedef struct packed {
    logic [7:0] vin;
    logic [7:0] vout;
    logic [7:0] vds;
    logic [7:0] ids;
    logic ilim;
    logic otemp;
  } sense_t;

endpackage

// [load_switch_soa_protection_fsm.sv]
// protection and sequencing state machine of a load switch
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// ------------------------------------------------------------
// What this block does
// - enable high starts the machine and turns the gate on.
// - lockout select picks one of two overvoltage cutoff levels.
// - the fault flag asserts on overvoltage, area trip, limit or heat.
// - the good flag asserts once output voltage passes its threshold.
// - dissipation is the product of drain-source voltage and current.
// - dissipation above the upper level turns the gate off at once.
// - after an area shutdown a restart follows the cool-down delay.
// - dissipation above the lower level starts the blanking timer.
// - still above the lower level at blanking end turns the gate off.
// - a lower-level shutdown also retries after the cool-down delay.
// - both levels are watched when on and during blanking, in limit or not.
// ------------------------------------------------------------
module load_switch_soa_protection_fsm
  import load_switch_pkg::*;
#(
  parameter logic [TIMER_W-1:0] BLANK_LEN = TIMER_W'(BLANK_CYCLES),
  parameter logic [TIMER_W-1:0] RETRY_LEN = TIMER_W'(RETRY_CYCLES)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // host pins
  input wire logic enable,
  input wire logic lockout_sel,
  // analog comparator and sense inputs
  input wire sense_t sense,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // power path and open-drain flags
  output logic gate_on,
  output logic fault_flag_o,
  output logic fault_flag_oe,
  output logic output_good_flag_o,
  output logic output_good_flag_oe
);

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  sw_state_t state_reg;
  sw_state_t state_next;
  logic gate_reg;
  logic gate_next;
  logic [15:0] power_reg;
  logic [15:0] power_next;
  logic [15:0] upper_thr_reg;
  logic [15:0] lower_thr_reg;
  logic [7:0] overvoltage_cutoff_lo_reg;
  logic [7:0] overvoltage_cutoff_hi_reg;
  logic [7:0] good_thr_reg;
  logic [EV_W-1:0] events_reg;
  logic [EV_W-1:0] events_next;
  logic [15:0] trips_reg;
  logic [15:0] trips_next;
  logic fault_oe_reg;
  logic fault_oe_next;
  logic good_oe_reg;
  logic good_oe_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] status_word;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [7:0] overvoltage_cutoff_thr;
  logic ov_hit;
  logic over_hi;
  logic over_lo;
  logic blank_done;
  logic retry_done;
  logic run_ok;
  logic trip_hi;
  logic trip_lo;
  logic good_now;
  logic wr_upper;
  logic wr_lower;
  logic wr_overvoltage_cutoff_lo;
  logic wr_overvoltage_cutoff_hi;
  logic wr_good;
  logic wr_events;
  logic [EV_W-1:0] ev_set;

  assign overvoltage_cutoff_thr = lockout_sel ? overvoltage_cutoff_hi_reg : overvoltage_cutoff_lo_reg;
  assign ov_hit = sense.vin > overvoltage_cutoff_thr;
  assign power_next = 16'(sense.vds) * 16'(sense.ids);
  // both tiers acted on only in st_on and st_blank, current limit or not
  assign over_hi = power_reg > upper_thr_reg;
  assign over_lo = power_reg > lower_thr_reg;
  assign run_ok = enable && !ov_hit && !sense.otemp;
  assign trip_hi = run_ok && over_hi &&
    ((state_reg == st_on) || (state_reg == st_blank));
  assign trip_lo = run_ok && !over_hi && over_lo && blank_done &&
    (state_reg == st_blank);
  assign good_now = gate_reg && (sense.vout > good_thr_reg);

  assign wr_upper = wr_stb && (addr == OFF_UPPER_PWR);
  assign wr_lower = wr_stb && (addr == OFF_LOWER_PWR);
  assign wr_overvoltage_cutoff_lo = wr_stb && (addr == OFF_OVERVOLTAGE_CUTOFF_LO);
  assign wr_overvoltage_cutoff_hi = wr_stb && (addr == OFF_OVERVOLTAGE_CUTOFF_HI);
  assign wr_good = wr_stb && (addr == OFF_GOOD_THR);
  assign wr_events = wr_stb && (addr == OFF_EVENTS);

  // ------------------------------------------------------------
  // timers
  // ------------------------------------------------------------
  protect_timer #(
    .LEN(BLANK_LEN)
  ) u_blank_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(state_reg == st_blank),
    .done(blank_done)
  );

  protect_timer #(
    .LEN(RETRY_LEN)
  ) u_retry_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(state_reg == st_retry),
    .done(retry_done)
  );

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (!enable) begin
      state_next = st_off;
    end else if (ov_hit || sense.otemp) begin
      state_next = st_off;
    end else begin
      case (state_reg)
        st_off: begin
          state_next = st_on;
        end
        st_on: begin
          if (over_hi) begin
            state_next = st_retry;
          end else if (over_lo) begin
            state_next = st_blank;
          end
        end
        st_blank: begin
          if (over_hi) begin
            state_next = st_retry;
          end else if (!over_lo) begin
            state_next = st_on;
          end else if (blank_done) begin
            state_next = st_retry;
          end
        end
        st_retry: begin
          if (retry_done) begin
            state_next = st_on;
          end
        end
        default: begin
          state_next = st_off;
        end
      endcase
    end
  end

  assign gate_next = (state_next == st_on) || (state_next == st_blank);

  // ------------------------------------------------------------
  // flags and events
  // ------------------------------------------------------------
  assign fault_oe_next = ov_hit || sense.otemp || sense.ilim ||
    trip_hi || trip_lo || (state_reg == st_retry);
  assign good_oe_next = !good_now;
  assign ev_set = {ov_hit, trip_lo, trip_hi};
  // set wins over a write-one clear
  assign events_next = wr_events ?
    ((events_reg & ~wdata[EV_W-1:0]) | ev_set) : (events_reg | ev_set);
  assign trips_next = (trip_hi || trip_lo) ? trips_reg + 16'h0001 :
    trips_reg;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[STAT_OV] = ov_hit;
    status_word[STAT_SEL] = lockout_sel;
    status_word[STAT_EN] = enable;
    status_word[STAT_GOOD] = !good_oe_reg;
    status_word[STAT_FAULT] = fault_oe_reg;
    status_word[STAT_GATE] = gate_reg;
    status_word[STAT_STATE +: 2] = state_reg;
  end

  always_comb begin
    rdata_next = '0;
    if (rd_stb) begin
      case (addr)
        OFF_STATUS: rdata_next = status_word;
        OFF_UPPER_PWR: rdata_next = {16'h0000, upper_thr_reg};
        OFF_LOWER_PWR: rdata_next = {16'h0000, lower_thr_reg};
        OFF_OVERVOLTAGE_CUTOFF_LO: rdata_next = {24'h000000, overvoltage_cutoff_lo_reg};
        OFF_OVERVOLTAGE_CUTOFF_HI: rdata_next = {24'h000000, overvoltage_cutoff_hi_reg};
        OFF_GOOD_THR: rdata_next = {24'h000000, good_thr_reg};
        OFF_EVENTS: rdata_next = {29'h0000000, events_reg};
        OFF_TRIPS: rdata_next = {16'h0000, trips_reg};
        OFF_POWER: rdata_next = {16'h0000, power_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // flops
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= st_off;
      gate_reg <= 1'b0;
      power_reg <= '0;
      fault_oe_reg <= 1'b0;
      good_oe_reg <= 1'b1;
      events_reg <= '0;
      trips_reg <= '0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      gate_reg <= gate_next;
      power_reg <= power_next;
      fault_oe_reg <= fault_oe_next;
      good_oe_reg <= good_oe_next;
      events_reg <= events_next;
      trips_reg <= trips_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      upper_thr_reg <= UPPER_PWR_RST;
      lower_thr_reg <= LOWER_PWR_RST;
      overvoltage_cutoff_lo_reg <= OVERVOLTAGE_CUTOFF_LO_RST;
      overvoltage_cutoff_hi_reg <= OVERVOLTAGE_CUTOFF_HI_RST;
      good_thr_reg <= GOOD_THR_RST;
    end else begin
      if (wr_upper) upper_thr_reg <= wdata[15:0];
      if (wr_lower) lower_thr_reg <= wdata[15:0];
      if (wr_overvoltage_cutoff_lo) overvoltage_cutoff_lo_reg <= wdata[7:0];
      if (wr_overvoltage_cutoff_hi) overvoltage_cutoff_hi_reg <= wdata[7:0];
      if (wr_good) good_thr_reg <= wdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign gate_on = gate_reg;
  assign fault_flag_o = 1'b0;
  assign fault_flag_oe = fault_oe_reg;
  assign output_good_flag_o = 1'b0;
  assign output_good_flag_oe = good_oe_reg;
  assign rdata = rdata_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_turn_on_enable: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == st_off && run_ok) |=> gate_reg && state_reg == st_on)
    else $error("gate did not turn on after enable");

  chk_overvoltage_cutoff_cutoff: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (sense.vin > (lockout_sel ? overvoltage_cutoff_hi_reg : overvoltage_cutoff_lo_reg))
      |=> !gate_reg && fault_flag_oe)
    else $error("overvoltage did not cut the gate");

  chk_fault_flag: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (sense.ilim || sense.otemp || trip_hi) |=> fault_flag_oe)
    else $error("fault flag missing after a fault cause");

  chk_good_flag: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (gate_reg && sense.vout > good_thr_reg) |=> !output_good_flag_oe)
    else $error("good flag not released above threshold");

  chk_power_calc: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> power_reg == 16'($past(sense.vds)) *
      16'($past(sense.ids)))
    else $error("power is not voltage times current");

  chk_upper_trip: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    trip_hi |=> !gate_reg && state_reg == st_retry)
    else $error("upper level did not cut the gate at once");

  chk_retry_restart: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == st_retry && retry_done && run_ok) |=> gate_reg)
    else $error("no restart after the cool-down delay");

  chk_retry_hold: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == st_retry && !retry_done) |=> !gate_reg)
    else $error("gate came back during cool-down");

  chk_blank_start: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == st_on && run_ok && over_lo && !over_hi)
      |=> state_reg == st_blank && gate_reg)
    else $error("blanking did not start on lower level");

  chk_blank_expire: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    trip_lo |=> !gate_reg && state_reg == st_retry)
    else $error("gate stayed on after blanking expired");

  chk_enable_off: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !enable |=> !gate_reg && state_reg == st_off)
    else $error("enable low did not turn the gate off");

  chk_blank_cancel: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (state_reg == st_blank && run_ok && !over_lo)
      |=> state_reg == st_on && gate_reg)
    else $error("blanking not cancelled below lower level");

endmodule // load_switch_soa_protection_fsm

// [protect_timer.sv]
// run timer that flags when it has run a set number of cycles
`timescale 1ns/1ps
module protect_timer
  import load_switch_pkg::*;
#(
  parameter logic [TIMER_W-1:0] LEN = 24'd100
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // control
  input wire logic run,
  output logic done
);

  logic [TIMER_W-1:0] count_reg;
  logic [TIMER_W-1:0] count_next;

  // ------------------------------------------------------------
  // count while running, clear otherwise
  // ------------------------------------------------------------
  assign count_next = run ? count_reg + 1'b1 : '0;
  assign done = run && (count_reg == LEN - 1'b1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // protect_timer

// [tb.sv]
// self-checking bench for the load switch protection block
`timescale 1ns/1ps
module tb;
  import load_switch_pkg::*;
  localparam int BL = 20;
  localparam int RL = 40;
  localparam logic [7:0] OFFS [6] = '{OFF_UPPER_PWR, OFF_LOWER_PWR,
    OFF_OVERVOLTAGE_CUTOFF_LO, OFF_OVERVOLTAGE_CUTOFF_HI, OFF_GOOD_THR, 8'h40};
  localparam logic [31:0] RSTV [6] = '{32'(UPPER_PWR_RST),
    32'(LOWER_PWR_RST), 32'(OVERVOLTAGE_CUTOFF_LO_RST), 32'(OVERVOLTAGE_CUTOFF_HI_RST),
    32'(GOOD_THR_RST), 32'h0};
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic ref_clk, nrst, want_en, want_sel, enable, lockout_sel;
  sense_t sense;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic wr_stb, rd_stb, gate_on, fault_o, fault_oe, good_o, good_oe;
  logic fault_pin, good_pin, rd_d, pin_req;
  logic [31:0] rd_q[$];
  logic [2:0] pin_q[$];
  int n_errors, n_tests, v, c;

  load_switch_soa_protection_fsm #(.BLANK_LEN(24'd20), .RETRY_LEN(24'd40))
    dut (.ref_clk(ref_clk), .nrst(nrst), .enable(enable),
    .lockout_sel(lockout_sel), .sense(sense), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .gate_on(gate_on),
    .fault_flag_o(fault_o), .fault_flag_oe(fault_oe),
    .output_good_flag_o(good_o), .output_good_flag_oe(good_oe));
  host_ctrl host (.ref_clk(ref_clk), .want_en(want_en), .want_sel(want_sel),
    .enable(enable), .lockout_sel(lockout_sel), .fault_o(fault_o),
    .fault_oe(fault_oe), .good_o(good_o), .good_oe(good_oe),
    .fault_pin(fault_pin), .good_pin(good_pin));

  always #5 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    tick(1);
    wr_stb <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    rd_stb <= 1'b1;
    addr <= a;
    tick(1);
    rd_stb <= 1'b0;
    tick(1);
  endtask
  // expected {gate, fault level, good level}
  task automatic pins(input logic [2:0] e);
    pin_q.push_back(e);
    pin_req <= 1'b1;
    tick(1);
    pin_req <= 1'b0;
    tick(1);
  endtask

  // ------------------------------------------------------------
  // monitor and compare
  // ------------------------------------------------------------
  task automatic fail(input string m);
    n_errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic cmp_rd();
    logic [31:0] e;
    e = rd_q.pop_front();
    n_tests++;
    if (rdata !== e) fail($sformatf("rdata %h exp %h", rdata, e));
  endtask
  task automatic cmp_pins();
    logic [2:0] e;
    e = pin_q.pop_front();
    n_tests++;
    if ({gate_on, fault_pin, good_pin} !== e)
      fail($sformatf("pins %b exp %b", {gate_on, fault_pin, good_pin}, e));
  endtask
  always @(posedge ref_clk) begin
    rd_d <= rd_stb;
    if (rd_d === 1'b1) cmp_rd();
    if (pin_req === 1'b1) cmp_pins();
  end

  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    want_en = 1'b0;
    want_sel = 1'b0;
    sense = '0;
    sense.vin = 8'h78;
    sense.vout = 8'h78;
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    pin_req = 1'b0;
    n_errors = 0;
    n_tests = 0;
    void'($urandom(53242));
    tick(20);
    nrst <= 1'b1;
    tick(2);
    pins(3'b010);
    for (int i = 0; i < 6; i++) rd(OFFS[i], RSTV[i]);
    wr(OFF_GOOD_THR, 32'h00000050);
    rd(OFF_GOOD_THR, 32'h00000050);
    wr(OFF_GOOD_THR, 32'(GOOD_THR_RST));
    wr(OFF_TRIPS, 32'h000000ff);
    rd(OFF_TRIPS, 32'h0);
    want_en <= 1'b1;
    tick(4);
    pins(3'b111);
    sense.vout <= 8'h50;
    tick(3);
    pins(3'b110);
    sense.vout <= 8'h78;
    sense.vds <= 8'h32;
    sense.ids <= 8'h3c;
    tick(4);
    pins(3'b000);
    rd(OFF_POWER, 32'h00000bb8);
    sense.ids <= 8'h00;
    tick(RL - 20);
    pins(3'b000);
    tick(30);
    pins(3'b111);
    rd(OFF_EVENTS, 32'h1);
    wr(OFF_EVENTS, 32'h7);
    rd(OFF_EVENTS, 32'h0);
    sense.vds <= 8'h1e;
    sense.ids <= 8'h32;
    tick(6);
    pins(3'b111);
    tick(BL);
    pins(3'b000);
    sense.ids <= 8'h00;
    tick(RL);
    pins(3'b111);
    rd(OFF_EVENTS, 32'h2);
    rd(OFF_TRIPS, 32'h2);
    sense.ids <= 8'h32;
    tick(8);
    sense.ids <= 8'h00;
    tick(BL + 10);
    pins(3'b111);
    rd(OFF_STATUS, 32'h0000006c);
    sense.ilim <= 1'b1;
    tick(4);
    pins(3'b101);
    sense.ids <= 8'h3c;
    sense.vds <= 8'h32;
    tick(4);
    pins(3'b000);
    want_en <= 1'b0;
    sense.ids <= 8'h00;
    sense.ilim <= 1'b0;
    tick(RL + 10);
    pins(3'b010);
    want_en <= 1'b1;
    tick(5);
    pins(3'b111);
    sense.vin <= 8'he6;
    tick(4);
    pins(3'b000);
    want_sel <= 1'b1;
    tick(5);
    pins(3'b111);
    sense.vin <= 8'hf5;
    tick(4);
    pins(3'b000);
    sense.vin <= 8'h78;
    sense.otemp <= 1'b1;
    tick(4);
    pins(3'b000);
    sense.otemp <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = $urandom_range(31);
      c = $urandom_range(31);
      sense.vds <= 8'(v);
      sense.ids <= 8'(c);
      tick(3);
      rd(OFF_POWER, 32'(v * c));
    end
    pins(3'b111);
    tick(2);
    summarize();
  end
endmodule // tb
